/* File: wdst_top.sv */
// Functional notes
// R1: Wait bit write-once, reset set, halts in wait
// R2: Doze bit write-once, reset set, halts in doze
// R3: Debug-halt bit write-once, stops in debug
// R4: Write-once bits lock except in debug
// R5: First write in debug leaves register writable
// R6: Registers accessible in debug, state resumes after
// R7: Debug-halt toggled in debug starts/stops counting
// R8: Disabled watchdog holds counter and prescaler
// R9: Reload write loads counter, kept for reloads
// R10: Reload field resets to ffff, write-once
// R11: Prescaler cleared on every counter load
// R12: Live count read-only, writes ignored, no error
// R13: Service 5555 then aaaa reloads counter
// R14: Timeout signals reset controller
// R15: Other service values restart the sequence
// R16: User-mode access ignored with transfer error
// R17: Sixteen-bit down-counter requests reset on underflow
// R18: Halted in stop mode, resumes afterwards
// R19: Prescaler divide ratio is a constant
`timescale 1ns/1ps
module wdst_top (
  input wire logic CLK,
  input wire logic ARST_N,
  input wdst_pkg::wdst_bus_req_t BUS_REQ,
  output wdst_pkg::wdst_bus_rsp_t BUS_RSP,
  input wire logic STOP_MODE,
  input wire logic WAIT_MODE,
  input wire logic DOZE_MODE,
  input wire logic DEBUG_MODE,
  output logic WDOG_RESET_REQ,
  output logic WDOG_ENABLED
);
  import wdst_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  wdst_state_t s_r;
  wdst_state_t s_nxt;

  logic presc_tick;
  logic presc_clr;
  logic run;
  logic [31:0] half_addr;

  assign BUS_RSP = s_r.rsp;
  assign WDOG_RESET_REQ = s_r.rst_req;
  assign WDOG_ENABLED = s_r.en;

  // Byte enables pick which lanes of a halfword are updated
  function automatic logic [15:0] merge_lanes(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0] be
  );
    logic [15:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (be[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res;
  endfunction : merge_lanes

  assign half_addr = {BUS_REQ.addr[31:1], 1'b0};

  // ****************************************************************
  // Run condition
  // ****************************************************************
  // Low-power and debug halts only freeze; nothing is reset, so
  // counting picks up exactly where it stopped.
  always_comb begin
    run = s_r.en; // [R8]
    if (STOP_MODE) begin
      run = 1'b0; // [R18]
    end
    if (WAIT_MODE && s_r.wait_sel) begin
      run = 1'b0; // [R1]
    end
    if (DOZE_MODE && s_r.doze) begin
      run = 1'b0; // [R2]
    end
    if (DEBUG_MODE && s_r.debug_halt_select) begin
      run = 1'b0; // [R3] [R6] [R7]
    end
  end

  wdst_prescaler u_presc (
    .clk(CLK),
    .arst_n(ARST_N),
    .run(run),
    .clr(presc_clr),
    .tick(presc_tick)
  ); // [R19]

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic loaded;
    logic [15:0] merged;
    logic [15:0] ctl_word;
    s_nxt = s_r;
    loaded = 1'b0;
    merged = 16'h0000;
    ctl_word = 16'h0000;
    presc_clr = 1'b0;
    s_nxt.rst_req = 1'b0;
    s_nxt.rsp.ack = 1'b0;
    s_nxt.rsp.err = 1'b0;
    s_nxt.rsp.rdata = 16'h0000;

    ctl_word[WDST_CTRL_EN_BIT] = s_r.en;
    ctl_word[WDST_CTRL_DEBUG_HALT_BIT] = s_r.debug_halt_select;
    ctl_word[WDST_CTRL_DOZE_BIT] = s_r.doze;
    ctl_word[WDST_CTRL_WAIT_BIT] = s_r.wait_sel;

    if (BUS_REQ.sel) begin
      if (!BUS_REQ.supv) begin
        s_nxt.rsp.err = 1'b1; // [R16]
      end else if (half_addr == WDST_ADDR_CONTROL) begin
        s_nxt.rsp.ack = 1'b1;
        s_nxt.rsp.rdata = ctl_word;
        // Control bits all sit in the low byte lane
        if (BUS_REQ.wr && BUS_REQ.be[0] && (!s_r.ctl_lock || DEBUG_MODE)) begin // [R4]
          merged = merge_lanes(ctl_word, BUS_REQ.wdata, BUS_REQ.be);
          s_nxt.en = merged[WDST_CTRL_EN_BIT];
          s_nxt.debug_halt_select = merged[WDST_CTRL_DEBUG_HALT_BIT]; // [R3] [R7]
          s_nxt.doze = merged[WDST_CTRL_DOZE_BIT]; // [R2]
          s_nxt.wait_sel = merged[WDST_CTRL_WAIT_BIT]; // [R1]
          if (!DEBUG_MODE) begin
            s_nxt.ctl_lock = 1'b1; // [R5]
          end
        end
      end else if (half_addr == WDST_ADDR_RELOAD) begin
        s_nxt.rsp.ack = 1'b1;
        s_nxt.rsp.rdata = s_r.reload_field; // [R9]
        if (BUS_REQ.wr && (BUS_REQ.be != 2'b00) && (!s_r.reload_lock || DEBUG_MODE)) begin // [R10]
          merged = merge_lanes(s_r.reload_field, BUS_REQ.wdata, BUS_REQ.be);
          s_nxt.reload_field = merged;
          s_nxt.count_field = merged; // [R9]
          loaded = 1'b1;
          if (!DEBUG_MODE) begin
            s_nxt.reload_lock = 1'b1; // [R5]
          end
        end
      end else if (half_addr == WDST_ADDR_LIVE_COUNT) begin
        // Live value; byte-wide reads may straddle a decrement
        s_nxt.rsp.ack = 1'b1;
        s_nxt.rsp.rdata = s_r.count_field; // [R12]
      end else if (half_addr == WDST_ADDR_SERVICE_KEY) begin
        s_nxt.rsp.ack = 1'b1;
        s_nxt.rsp.rdata = s_r.service_field;
        if (BUS_REQ.wr && (BUS_REQ.be != 2'b00)) begin
          merged = merge_lanes(s_r.service_field, BUS_REQ.wdata, BUS_REQ.be);
          s_nxt.service_field = merged;
          if (merged == WDST_KEY_FIRST) begin
            s_nxt.armed = 1'b1; // [R13]
          end else if (merged == WDST_KEY_SECOND) begin
            if (s_r.armed && s_r.en) begin
              s_nxt.count_field = s_r.reload_field; // [R13]
              loaded = 1'b1;
            end
            s_nxt.armed = 1'b0;
          end else begin
            s_nxt.armed = 1'b0; // [R15]
          end
        end
      end else begin
        // Unmapped halfword inside the select: no effect, error
        s_nxt.rsp.err = 1'b1;
      end
    end

    // ****************************************************************
    // Down-counter
    // ****************************************************************
    // A bus load wins over a tick in the same cycle, so a service
    // landing on the last count still prevents the reset.
    if (!loaded && presc_tick) begin
      if (s_r.count_field == 16'h0000) begin
        s_nxt.rst_req = 1'b1; // [R14] [R17]
        s_nxt.count_field = s_r.reload_field;
        loaded = 1'b1;
      end else begin
        s_nxt.count_field = s_r.count_field - 16'h0001; // [R17]
      end
    end

    presc_clr = loaded; // [R11]
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_r.en <= WDST_RST_EN;
      s_r.debug_halt_select <= WDST_RST_DEBUG_HALT;
      s_r.doze <= WDST_RST_DOZE; // [R2]
      s_r.wait_sel <= WDST_RST_WAIT; // [R1]
      s_r.ctl_lock <= 1'b0;
      s_r.reload_lock <= 1'b0;
      s_r.reload_field <= WDST_RST_RELOAD; // [R10]
      s_r.count_field <= WDST_RST_RELOAD;
      s_r.service_field <= WDST_RST_SERVICE;
      s_r.armed <= 1'b0;
      s_r.rst_req <= 1'b0;
      s_r.rsp <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : wdst_top

/* File: wdst_pkg.sv */
package wdst_pkg;

  // ****************************************************************
  // Register map (byte addresses of each halfword register)
  // ****************************************************************
  localparam logic [31:0] WDST_ADDR_CONTROL = 32'h00c70000;
  localparam logic [31:0] WDST_ADDR_RELOAD = 32'h00c70002;
  localparam logic [31:0] WDST_ADDR_LIVE_COUNT = 32'h00c70004;
  localparam logic [31:0] WDST_ADDR_SERVICE_KEY = 32'h00c70006;

  // ****************************************************************
  // Control register field positions
  // ****************************************************************
  localparam int WDST_CTRL_EN_BIT = 0;
  localparam int WDST_CTRL_DEBUG_HALT_BIT = 1;
  localparam int WDST_CTRL_DOZE_BIT = 2;
  localparam int WDST_CTRL_WAIT_BIT = 3;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic WDST_RST_EN = 1'b1;
  localparam logic WDST_RST_DEBUG_HALT = 1'b0;
  localparam logic WDST_RST_DOZE = 1'b1;
  localparam logic WDST_RST_WAIT = 1'b1;
  localparam logic [15:0] WDST_RST_RELOAD = 16'hffff;
  localparam logic [15:0] WDST_RST_SERVICE = 16'h0000;

  // ****************************************************************
  // Service keys and prescaler
  // ****************************************************************
  localparam logic [15:0] WDST_KEY_FIRST = 16'h5555;
  localparam logic [15:0] WDST_KEY_SECOND = 16'haaaa;
  localparam int WDST_PRESC_W = 12;
  // Divide ratio is 4096 system clocks per count
  localparam logic [WDST_PRESC_W-1:0] WDST_PRESC_LAST = 12'hfff;
  localparam logic [WDST_PRESC_W-1:0] WDST_PRESC_ZERO = 12'h000;

  // ****************************************************************
  // Carriers and state
  // ****************************************************************
  typedef struct packed {
    logic sel;
    logic wr;
    logic supv;
    logic [31:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } wdst_bus_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } wdst_bus_rsp_t;

  typedef struct packed {
    logic en;
    logic debug_halt_select;
    logic doze;
    logic wait_sel;
    logic ctl_lock;
    logic reload_lock;
    logic [15:0] reload_field;
    logic [15:0] count_field;
    logic [15:0] service_field;
    logic armed;
    logic rst_req;
    wdst_bus_rsp_t rsp;
  } wdst_state_t;

  typedef struct packed {
    logic [WDST_PRESC_W-1:0] cnt;
  } wdst_presc_state_t;

endpackage : wdst_pkg

/* File: wdst_prescaler.sv */
`timescale 1ns/1ps
module wdst_prescaler (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic clr,
  output logic tick
);
  import wdst_pkg::*;

  wdst_presc_state_t s_r;
  wdst_presc_state_t s_nxt;

  // One-cycle enable pulse at the end of each prescaler period.
  // Not gated by clr: the parent derives clr from tick, a loop
  assign tick = run && (s_r.cnt == WDST_PRESC_LAST);

  always_comb begin
    s_nxt = s_r;
    if (clr) begin
      s_nxt.cnt = WDST_PRESC_ZERO;
    end else if (run) begin
      if (s_r.cnt == WDST_PRESC_LAST) begin
        s_nxt.cnt = WDST_PRESC_ZERO;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r.cnt <= WDST_PRESC_ZERO;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : wdst_prescaler

/* File: wdst_rstctl_model.sv */
`timescale 1ns/1ps
// ****
// Reset controller stand-in
// ****
module wdst_rstctl_model (
  input wire logic clk,
  input wire logic por_n,
  input wire logic req,
  output logic cause_flag
);
  // Cleared by power-on only, so the flag outlives the watchdog reset
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      cause_flag <= 1'b0;
    end else if (req) begin
      cause_flag <= 1'b1;
    end
  end
endmodule : wdst_rstctl_model

/* File: wdst_asserts.sv */
`timescale 1ns/1ps
module wdst_chk (
  input wire logic CLK,
  input wire logic ARST_N,
  input wdst_pkg::wdst_bus_req_t BUS_REQ,
  input wdst_pkg::wdst_bus_rsp_t BUS_RSP,
  input wire logic STOP_MODE,
  input wire logic WAIT_MODE,
  input wire logic DOZE_MODE,
  input wire logic DEBUG_MODE,
  input wire logic WDOG_RESET_REQ,
  input wire logic WDOG_ENABLED
);
  import wdst_pkg::*;
  // ****
  // Bus and timeout properties
  // ****
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  a_one_answer:
  assert property (BUS_REQ.sel |=> BUS_RSP.ack ^ BUS_RSP.err) else $error("bad answer");
  a_no_answer:
  assert property (!BUS_REQ.sel |=> !(BUS_RSP.ack | BUS_RSP.err)) else $error("stray answer");
  a_user_error:
  assert property (BUS_REQ.sel && !BUS_REQ.supv |=> BUS_RSP.err) else $error("user not refused");
  a_user_noeffect:
  assert property (BUS_REQ.sel && !BUS_REQ.supv && BUS_REQ.wr |=> ##1
    WDOG_ENABLED == $past(WDOG_ENABLED, 2)) else $error("user write took effect");
  a_count_wr_ok:
  assert property (BUS_REQ.sel && BUS_REQ.supv && BUS_REQ.wr &&
    BUS_REQ.addr == WDST_ADDR_LIVE_COUNT |=> BUS_RSP.ack) else $error("count write refused");
  a_req_pulse:
  assert property (WDOG_RESET_REQ |=> !WDOG_RESET_REQ [*8]) else $error("request too long");
  a_stop_holds:
  assert property (STOP_MODE |=> !WDOG_RESET_REQ) else $error("ran in stop");
  a_off_quiet:
  assert property (!WDOG_ENABLED |=> !WDOG_RESET_REQ) else $error("ran while off");
  c_req: cover property (WDOG_RESET_REQ);
  c_err: cover property (BUS_RSP.err);
  c_stop: cover property (STOP_MODE ##1 !STOP_MODE);
endmodule : wdst_chk
bind wdst_top wdst_chk u_chk (.CLK(CLK), .ARST_N(ARST_N), .BUS_REQ(BUS_REQ),
  .BUS_RSP(BUS_RSP), .STOP_MODE(STOP_MODE), .WAIT_MODE(WAIT_MODE), .DOZE_MODE(DOZE_MODE),
  .DEBUG_MODE(DEBUG_MODE), .WDOG_RESET_REQ(WDOG_RESET_REQ), .WDOG_ENABLED(WDOG_ENABLED));

/* File: watchdog_service_timer_bench.sv */
`timescale 1ns/1ps
module watchdog_service_timer_bench;
  import wdst_pkg::*;
  localparam logic [31:0] CTL = WDST_ADDR_CONTROL;
  localparam logic [31:0] RLD = WDST_ADDR_RELOAD;
  localparam logic [31:0] CNT = WDST_ADDR_LIVE_COUNT;
  localparam logic [31:0] KEY = WDST_ADDR_SERVICE_KEY;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic por_n = 1'b0;
  logic stop_m = 1'b0;
  logic wait_m = 1'b0;
  logic dbg_m = 1'b0;
  logic doze_m = 1'b0;
  logic wreq, wen, flag, e, k;
  logic [15:0] q;
  wdst_bus_req_t req = '0;
  wdst_bus_rsp_t rsp;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  wdst_top dut (.CLK(clk), .ARST_N(arst_n), .BUS_REQ(req), .BUS_RSP(rsp), .STOP_MODE(stop_m),
    .WAIT_MODE(wait_m), .DOZE_MODE(doze_m), .DEBUG_MODE(dbg_m), .WDOG_RESET_REQ(wreq),
    .WDOG_ENABLED(wen));
  wdst_rstctl_model rc (.clk(clk), .por_n(por_n), .req(wreq), .cause_flag(flag));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic results();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // Roughly 47k cycles are needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  // One-cycle strobe; answer taken at the rising edge after the taking edge
  task automatic acc(input logic w, input logic s, input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{sel: 1'b1, wr: w, supv: s, addr: a, be: 2'h3, wdata: d};
    @(posedge clk);
    req.sel <= 1'b0;
    @(posedge clk);
    q = rsp.rdata;
    e = rsp.err;
    k = rsp.ack;
  endtask : acc
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    acc(1'b1, 1'b1, a, d);
  endtask : wr
  task automatic rdc(input string n, input logic [31:0] a, input logic [15:0] x);
    acc(1'b0, 1'b1, a, 16'h0000);
    chk(n, q, x);
  endtask : rdc
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    por_n <= 1'b1;
    rdc("ctl", CTL, 16'h000d);
    rdc("rld", RLD, 16'hffff);
    rdc("key", KEY, 16'h0000);
    acc(1'b1, 1'b0, CTL, 16'h0000);
    chk("usr err", {15'h0000, e}, 16'h0001);
    chk("usr ack", {15'h0000, k}, 16'h0000);
    rdc("ctl", CTL, 16'h000d);
    acc(1'b0, 1'b1, 32'h00c70008, 16'h0000);
    chk("map err", {15'h0000, e}, 16'h0001);
    dbg_m <= 1'b1;
    wr(CTL, 16'h000b);
    wr(RLD, 16'h0003);
    rdc("cnt", CNT, 16'h0003);
    repeat (4200) @(posedge clk);
    rdc("cnt", CNT, 16'h0003);
    wr(CTL, 16'h0009);
    repeat (4200) @(posedge clk);
    rdc("cnt", CNT, 16'h0002);
    dbg_m <= 1'b0;
    wr(CTL, 16'h0001);
    wr(CTL, 16'h000f);
    rdc("ctl", CTL, 16'h0001);
    wr(RLD, 16'h0002);
    wr(RLD, 16'h0005);
    rdc("rld", RLD, 16'h0002);
    wr(CNT, 16'h1234);
    chk("cnt wr", {15'h0000, e}, 16'h0000);
    chk("cnt ack", {15'h0000, k}, 16'h0001);
    rdc("cnt", CNT, 16'h0002);
    repeat (4200) @(posedge clk);
    wr(KEY, WDST_KEY_FIRST);
    rdc("ctl", CTL, 16'h0001);
    wr(KEY, WDST_KEY_SECOND);
    rdc("cnt", CNT, 16'h0002);
    repeat (4200) @(posedge clk);
    wr(KEY, WDST_KEY_FIRST);
    wr(KEY, 16'h1234);
    wr(KEY, WDST_KEY_SECOND);
    rdc("cnt", CNT, 16'h0001);
    stop_m <= 1'b1;
    repeat (9000) @(posedge clk);
    stop_m <= 1'b0;
    rdc("cnt", CNT, 16'h0001);
    wait_m <= 1'b1;
    for (int i = 0; i < 9000 && wreq !== 1'b1; i++) @(posedge clk);
    chk("req", {15'h0000, wreq}, 16'h0001);
    rdc("cnt", CNT, 16'h0002);
    chk("flag", {15'h0000, flag}, 16'h0001);
    wait_m <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    wait_m <= 1'b1;
    repeat (4200) @(posedge clk);
    rdc("cnt", CNT, 16'hffff);
    wait_m <= 1'b0;
    doze_m <= 1'b1;
    repeat (4200) @(posedge clk);
    rdc("cnt", CNT, 16'hffff);
    doze_m <= 1'b0;
    wr(CTL, 16'h0000);
    repeat (4200) @(posedge clk);
    rdc("cnt", CNT, 16'hffff);
    chk("en", {15'h0000, wen}, 16'h0000);
    results();
  end
endmodule : watchdog_service_timer_bench
